// ===== design/bcd_ops_pkg.sv
// Constants, types and operation codes for the bit clear, complement and
// decimal adjust datapath. Assumes the core supplies a decoded operation.
// Function
// RL1: Whole-byte clear writes zero to the addressed byte; flags stay unchanged.
// RL2: Single-bit clear zeroes only the selected bit; other bits and flags stay.
// RL3: Watchdog clear restarts the counter and clears timeout and power-down flags; the code lets a same-cycle set (or expiry, for timeout) win.
// RL4: In-place complement inverts the byte, writes it back, updates zero flag.
// RL5: Complement to accumulator loads inverted byte, memory untouched, updates zero.
// RL6: Decimal adjust adds 6 to low nibble if above 9 or aux carry set.
// RL7: Decimal adjust adds 6 to high nibble if above 9 or carry set.
// RL8: Decimal adjust sources the accumulator and stores into the addressed byte.
// RL9: Decimal adjust changes only carry; correction is 00h, 06h, 60h or 66h.
// RL10: Zero flag set when the 8-bit result is zero, else cleared.
package bcd_ops_pkg;
    localparam int          DATA_W     = 8;
    localparam logic [3:0]  NIB_MAX    = 4'h9;
    localparam logic [7:0]  ADJ_LOW    = 8'h06;
    localparam logic [7:0]  ADJ_HIGH   = 8'h60;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam int          WDT_W      = 16;
    localparam logic [15:0] WDT_RST    = 16'h0000;
    localparam logic [15:0] WDT_LIMIT  = 16'hffff;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_CLEAR_OPERAND,
        OP_CLEAR_BIT,
        OP_CLEAR_WATCHDOG,
        OP_INVERT_IN_PLACE,
        OP_INVERT_TO_ACC,
        OP_DECIMAL_ADJUST
    } op_t;

    // One issued instruction with its operand
    typedef struct packed {
        op_t        op;
        logic [2:0] bit_sel;
        logic [7:0] operand;
    } req_t;

    // Memory write-back
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } wr_t;

    // Status flags kept by this block
    typedef struct packed {
        logic zero_flag;
        logic carry_flag;
        logic timeout_flag;
        logic powerdown_flag;
    } flags_t;
endpackage

// ===== design/decimal_adjust.sv
// Combinational BCD correction of the accumulator after an addition.
// Assumes carry and aux carry come from that preceding addition.
`timescale 1ns/1ps
module decimal_adjust
    import bcd_ops_pkg::*;
(
    input  wire logic [7:0] acc_in,
    input  wire logic       carry_in,
    input  wire logic       aux_carry_in,
    output logic      [7:0] result_out,
    output logic            carry_out
);
    logic       low_fix;
    logic       high_fix;
    logic [8:0] low_sum;
    logic [8:0] full_sum;
    logic [7:0] corr;

    // Low nibble first; its carry may push the high nibble past 9
    always_comb begin
        low_fix  = (acc_in[3:0] > NIB_MAX) || aux_carry_in;        // see RL6
        corr     = low_fix ? ADJ_LOW : BYTE_ZERO;
        low_sum  = {1'b0, acc_in} + {1'b0, corr};
        high_fix = (low_sum[7:4] > NIB_MAX) || carry_in || low_sum[8]; // see RL7
        if (high_fix) begin
            corr = corr | ADJ_HIGH;                                 // see RL9
        end
        full_sum   = {1'b0, acc_in} + {1'b0, corr};
        result_out = full_sum[7:0];
        carry_out  = carry_in | full_sum[8];                        // see RL9
    end
endmodule

// ===== design/bit_clear_complement_bcd_adjust.sv
// Execution datapath for clear, complement, watchdog clear and decimal adjust.
// Assumes a one-cycle op_valid pulse with the memory operand already read.
`timescale 1ns/1ps
module bit_clear_complement_bcd_adjust
    import bcd_ops_pkg::*;
#(
    parameter int WDT_BITS = WDT_W
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic         op_valid_in,
    input  wire req_t         req_in,
    input  wire logic [7:0]   accumulator_in,
    input  wire logic         aux_carry_flag_in,
    input  wire logic         timeout_set_in,
    input  wire logic         powerdown_set_in,
    output wr_t               mem_wr_out,
    output logic              acc_we_out,
    output logic [7:0]        accumulator_out,
    output flags_t            flags_out,
    output logic [WDT_BITS-1:0] watchdog_counter_out,
    output logic              watchdog_expired_out
);
    // Registered state, then combinational decode nets; every output below is built only from these registers
    wr_t                 mem_wr_ff;
    logic                acc_we_ff;
    logic [7:0]          acc_ff;
    logic                zero_ff;
    logic                carry_ff;
    logic                timeout_ff;
    logic                pdown_ff;
    logic [WDT_BITS-1:0] wdt_ff;
    logic [7:0]          adj_result;
    logic                adj_carry;
    logic [7:0]          inv_operand;
    logic                is_op;
    logic                do_wdt_clear;
    logic                do_inv_acc;

    // Decode of one issued op, shared by the flag, counter and accumulator processes
    function automatic logic op_hit(input logic valid, input op_t got, input op_t want);
        return valid && (got == want);
    endfunction

    function automatic logic is_zero(input logic [7:0] v);
        return v == BYTE_ZERO;                                     // see RL10
    endfunction

    decimal_adjust u_adj (
        .acc_in       (accumulator_in),
        .carry_in     (carry_ff),
        .aux_carry_in (aux_carry_flag_in),
        .result_out   (adj_result),
        .carry_out    (adj_carry)
    );

    // Operand inverse and op decodes, used by several processes
    assign inv_operand  = ~req_in.operand;
    assign is_op        = op_valid_in;
    assign do_wdt_clear = op_hit(is_op, req_in.op, OP_CLEAR_WATCHDOG);
    assign do_inv_acc   = op_hit(is_op, req_in.op, OP_INVERT_TO_ACC);

    // Memory write-back, one cycle after the request
    // Data holds after the pulse, so a slow reader still sees the last byte written
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mem_wr_ff <= '0;
        end else begin
            mem_wr_ff.we   <= 1'b0;
            mem_wr_ff.data <= mem_wr_ff.data;
            if (is_op) begin
                case (req_in.op)
                    OP_CLEAR_OPERAND: begin
                        mem_wr_ff <= '{we: 1'b1, data: BYTE_ZERO};      // see RL1
                    end
                    OP_CLEAR_BIT: begin
                        mem_wr_ff.we   <= 1'b1;
                        mem_wr_ff.data <= req_in.operand & ~(8'h01 << req_in.bit_sel); // see RL2
                    end
                    OP_INVERT_IN_PLACE: begin
                        mem_wr_ff <= '{we: 1'b1, data: inv_operand};    // see RL4
                    end
                    OP_DECIMAL_ADJUST: begin
                        mem_wr_ff <= '{we: 1'b1, data: adj_result};     // see RL8
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Accumulator load; memory is not written for this op
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            acc_we_ff <= 1'b0;
            acc_ff    <= ACC_RST;
        end else begin
            acc_we_ff <= do_inv_acc;
            if (do_inv_acc) begin
                acc_ff <= inv_operand;                              // see RL5
            end
        end
    end

    // Zero and carry; clears and adjust leave zero alone
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            zero_ff  <= 1'b0;
            carry_ff <= 1'b0;
        end else if (is_op) begin
            if (req_in.op == OP_INVERT_IN_PLACE || req_in.op == OP_INVERT_TO_ACC) begin
                zero_ff <= is_zero(inv_operand);                    // see RL4 RL5 RL10
            end
            if (req_in.op == OP_DECIMAL_ADJUST) begin
                carry_ff <= adj_carry;                              // see RL9
            end
        end
    end

    // Timeout and power-down; a set arriving with the clear wins so no event is lost
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            timeout_ff <= 1'b0;
            pdown_ff   <= 1'b0;
        end else begin
            if (timeout_set_in || wdt_ff == WDT_LIMIT[WDT_BITS-1:0]) begin
                timeout_ff <= 1'b1;
            end else if (do_wdt_clear) begin
                timeout_ff <= 1'b0;                                 // see RL3
            end
            if (powerdown_set_in) begin
                pdown_ff <= 1'b1;
            end else if (do_wdt_clear) begin
                pdown_ff <= 1'b0;                                   // see RL3
            end
        end
    end

    // Watchdog counter; wraps after expiry until software clears it
    // Free-running by choice: a missed clear re-arms the timeout every full count
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wdt_ff <= WDT_RST[WDT_BITS-1:0];
        end else if (do_wdt_clear) begin
            wdt_ff <= WDT_RST[WDT_BITS-1:0];                        // see RL3
        end else begin
            wdt_ff <= wdt_ff + 1'b1;
        end
    end

    assign mem_wr_out           = mem_wr_ff;
    assign acc_we_out           = acc_we_ff;
    assign accumulator_out      = acc_ff;
    assign flags_out            = '{zero_flag: zero_ff, carry_flag: carry_ff,
                                    timeout_flag: timeout_ff, powerdown_flag: pdown_ff};
    assign watchdog_counter_out = wdt_ff;
    assign watchdog_expired_out = timeout_ff;

    // Operation results; each attempt is off while reset is high
    clear_byte_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL1
        op_valid_in && req_in.op == OP_CLEAR_OPERAND |=> mem_wr_out.we && mem_wr_out.data == 8'h00)
        else $error("byte clear did not write zero");
    clear_flags_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL1 RL2
        op_valid_in && (req_in.op == OP_CLEAR_OPERAND || req_in.op == OP_CLEAR_BIT)
        |=> $stable(zero_ff) && $stable(carry_ff))
        else $error("clear changed a flag");
    clear_bit_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL2
        op_valid_in && req_in.op == OP_CLEAR_BIT |=> mem_wr_out.we && mem_wr_out.data[$past(req_in.bit_sel)] == 1'b0
        && (mem_wr_out.data | (8'h01 << $past(req_in.bit_sel)))
        == ($past(req_in.operand) | (8'h01 << $past(req_in.bit_sel))))
        else $error("bit clear wrong");
    invert_mem_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL4 RL10
        op_valid_in && req_in.op == OP_INVERT_IN_PLACE
        |=> mem_wr_out.data == ~$past(req_in.operand) && zero_ff == ($past(req_in.operand) == 8'hff))
        else $error("in-place invert wrong");
    invert_acc_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL5
        op_valid_in && req_in.op == OP_INVERT_TO_ACC
        |=> !mem_wr_out.we && acc_we_out && accumulator_out == ~$past(req_in.operand))
        else $error("invert to accumulator wrong");
    adj_store_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL8 RL9
        op_valid_in && req_in.op == OP_DECIMAL_ADJUST |=> mem_wr_out.we && $stable(zero_ff))
        else $error("decimal adjust store wrong");

    // Decimal adjust correction, checked on the live accumulator every cycle
    adj_low_a: assert property (@(posedge clk_in) // see RL6
        (accumulator_in[3:0] > 4'h9 || aux_carry_flag_in) |-> adj_result[3:0] == accumulator_in[3:0] + 4'h6)
        else $error("low nibble not corrected");
    adj_high_a: assert property (@(posedge clk_in) // see RL7 RL9
        carry_ff |-> adj_carry && (adj_result - accumulator_in) inside {8'h60, 8'h66})
        else $error("high nibble not corrected");

    // Watchdog clear, expiry and counting; a set or an expiry beats the clear
    wdt_clear_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL3
        op_valid_in && req_in.op == OP_CLEAR_WATCHDOG && !powerdown_set_in |=> wdt_ff == '0 && !pdown_ff)
        else $error("watchdog clear failed");
    timeout_clr_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL3
        do_wdt_clear && !timeout_set_in && wdt_ff != WDT_LIMIT[WDT_BITS-1:0] |=> !timeout_ff)
        else $error("watchdog clear left timeout set");
    expiry_set_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !srst_in && wdt_ff == WDT_LIMIT[WDT_BITS-1:0] |=> timeout_ff && watchdog_expired_out)
        else $error("watchdog expiry did not set timeout");
    wdt_count_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !srst_in && !do_wdt_clear |=> wdt_ff == $past(wdt_ff) + 1'b1)
        else $error("watchdog counter did not advance");

    // Only the intended target and flags move; guards against stray writes
    acc_hold_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL8
        !srst_in && !do_inv_acc |=> !acc_we_out && $stable(accumulator_out))
        else $error("accumulator written by another op");
    mem_quiet_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL5
        !srst_in && (!op_valid_in || req_in.op inside {OP_NONE, OP_CLEAR_WATCHDOG, OP_INVERT_TO_ACC})
        |=> !mem_wr_out.we)
        else $error("memory written by a non-memory op");
    carry_keep_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL1 RL2 RL3
        !srst_in && !(op_valid_in && req_in.op == OP_DECIMAL_ADJUST) |=> $stable(carry_ff))
        else $error("carry changed outside decimal adjust");
    zero_keep_a: assert property (@(posedge clk_in) disable iff (srst_in) // see RL3 RL9
        !srst_in && !(op_valid_in && req_in.op inside {OP_INVERT_IN_PLACE, OP_INVERT_TO_ACC})
        |=> $stable(zero_ff))
        else $error("zero changed outside complement");

    // Main scenarios
    cov_adjust_c: cover property (@(posedge clk_in)
        op_valid_in && req_in.op == OP_DECIMAL_ADJUST && adj_carry);
    cov_zero_c:   cover property (@(posedge clk_in)
        op_valid_in && req_in.op == OP_INVERT_TO_ACC && req_in.operand == 8'hff);
    cov_wdt_c:    cover property (@(posedge clk_in)
        op_valid_in && req_in.op == OP_CLEAR_WATCHDOG && timeout_ff);
    cov_clrbit_c: cover property (@(posedge clk_in)
        op_valid_in && req_in.op == OP_CLEAR_BIT && req_in.bit_sel == 3'h7);
    cov_expire_c: cover property (@(posedge clk_in)
        wdt_ff == WDT_LIMIT[WDT_BITS-1:0]);
endmodule

// ===== tb/tb.sv
// Self-checking bench for the clear, complement and decimal adjust datapath.
// Drives the ports directly; the watchdog is shortened to 4 bits.
`timescale 1ns/1ps
module tb
    import bcd_ops_pkg::*;
;
    logic       clk_in            = 1'b0;
    logic       srst_in           = 1'b1;
    logic       op_valid_in       = 1'b0;
    req_t       req_in            = '0;
    logic [7:0] accumulator_in    = 8'h00;
    logic       aux_carry_flag_in = 1'b0;
    logic       timeout_set_in    = 1'b0;
    logic       powerdown_set_in  = 1'b0;
    wr_t        mem_wr_out;
    logic       acc_we_out;
    logic [7:0] accumulator_out;
    flags_t     flags_out;
    logic [3:0] watchdog_counter_out;
    logic       watchdog_expired_out;
    int         n_errors          = 0;
    int         tests_run         = 0;
    // Decimal adjust cases; the carry-setting ones come last since carry only clears on reset
    logic [7:0] daa_acc [6]       = '{8'h45, 8'h4b, 8'h42, 8'h99, 8'h9a, 8'h12};
    logic       daa_aux [6]       = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [7:0] daa_res [6]       = '{8'h45, 8'h51, 8'h48, 8'h99, 8'h00, 8'h72};
    logic       daa_cy  [6]       = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    bit_clear_complement_bcd_adjust #(.WDT_BITS(4)) bit_clear_complement_bcd_adjust_inst (
        .clk_in(clk_in), .srst_in(srst_in), .op_valid_in(op_valid_in), .req_in(req_in),
        .accumulator_in(accumulator_in), .aux_carry_flag_in(aux_carry_flag_in),
        .timeout_set_in(timeout_set_in), .powerdown_set_in(powerdown_set_in),
        .mem_wr_out(mem_wr_out), .acc_we_out(acc_we_out), .accumulator_out(accumulator_out),
        .flags_out(flags_out), .watchdog_counter_out(watchdog_counter_out),
        .watchdog_expired_out(watchdog_expired_out));

    // Free-running core clock, 8 ns period
    always begin
        #4 clk_in = ~clk_in;
    end

    // Counts every comparison and reports each mismatch
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One issued op; returns just after the answering edge so the outputs have settled
    task automatic run_op(input op_t op, input logic [2:0] b, input logic [7:0] opnd,
                          input logic [7:0] acc, input logic aux);
        @(posedge clk_in);
        op_valid_in       <= 1'b1;
        req_in            <= '{op: op, bit_sel: b, operand: opnd};
        accumulator_in    <= acc;
        aux_carry_flag_in <= aux;
        @(posedge clk_in);
        op_valid_in       <= 1'b0;
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Generous bound: the tests need about 66 cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        check("flags after reset", {4'h0, flags_out}, 8'h00);
        check("write after reset", {7'h00, mem_wr_out.we}, 8'h00);
        // Complement in place, all ones gives zero
        run_op(OP_INVERT_IN_PLACE, 3'h0, 8'hff, 8'h00, 1'b0);
        check("inv we", {7'h00, mem_wr_out.we}, 8'h01);
        check("inv data", mem_wr_out.data, 8'h00);
        check("inv zero", {7'h00, flags_out.zero_flag}, 8'h01);
        check("inv acc we", {7'h00, acc_we_out}, 8'h00);
        run_op(OP_INVERT_IN_PLACE, 3'h0, 8'h5a, 8'h00, 1'b0);
        check("inv data2", mem_wr_out.data, 8'ha5);
        check("inv zero2", {7'h00, flags_out.zero_flag}, 8'h00);
        $display("test invert in place done");
        // Complement into the accumulator, memory left alone
        run_op(OP_INVERT_TO_ACC, 3'h0, 8'hff, 8'h33, 1'b0);
        check("invert_operand_to_accumulator acc we", {7'h00, acc_we_out}, 8'h01);
        check("invert_operand_to_accumulator acc", accumulator_out, 8'h00);
        check("invert_operand_to_accumulator mem we", {7'h00, mem_wr_out.we}, 8'h00);
        check("invert_operand_to_accumulator zero", {7'h00, flags_out.zero_flag}, 8'h01);
        run_op(OP_INVERT_TO_ACC, 3'h0, 8'h0f, 8'h33, 1'b0);
        check("invert_operand_to_accumulator acc2", accumulator_out, 8'hf0);
        check("invert_operand_to_accumulator zero2", {7'h00, flags_out.zero_flag}, 8'h00);
        $display("test invert to accumulator done");
        // Whole-byte clear must not touch the zero flag even though the result is zero
        run_op(OP_CLEAR_OPERAND, 3'h0, 8'h5a, 8'h00, 1'b0);
        check("clr we", {7'h00, mem_wr_out.we}, 8'h01);
        check("clr data", mem_wr_out.data, 8'h00);
        check("clr flags", {6'h00, flags_out.zero_flag, flags_out.carry_flag}, 8'h00);
        $display("test clear byte done");
        // Every bit position of the single-bit clear
        for (int i = 0; i < 8; i++) begin
            run_op(OP_CLEAR_BIT, 3'(i), 8'hff, 8'h00, 1'b0);
            check("clrbit data", mem_wr_out.data, ~(8'h01 << i));
            check("clrbit flags", {6'h00, flags_out.zero_flag, flags_out.carry_flag}, 8'h00);
        end
        $display("test clear bit done");
        // Decimal adjust stores to memory and changes carry only
        for (int i = 0; i < 6; i++) begin
            run_op(OP_DECIMAL_ADJUST, 3'h0, 8'hc3, daa_acc[i], daa_aux[i]);
            check("daa we", {7'h00, mem_wr_out.we}, 8'h01);
            check("daa data", mem_wr_out.data, daa_res[i]);
            check("daa carry", {7'h00, flags_out.carry_flag}, {7'h00, daa_cy[i]});
            check("daa zero", {7'h00, flags_out.zero_flag}, 8'h00);
            check("daa acc we", {7'h00, acc_we_out}, 8'h00);
        end
        $display("test decimal adjust done");
        // An idle op code must do nothing
        run_op(OP_NONE, 3'h0, 8'h00, 8'h00, 1'b0);
        check("none we", {6'h00, mem_wr_out.we, acc_we_out}, 8'h00);
        $display("test idle op done");
        // Clear first so the counter is known and both flags start low
        run_op(OP_CLEAR_WATCHDOG, 3'h0, 8'h00, 8'h00, 1'b0);
        check("wdt flags idle", {6'h00, flags_out.timeout_flag, flags_out.powerdown_flag}, 8'h00);
        // Set both flags by hardware, then the watchdog clear drops them
        @(posedge clk_in);
        timeout_set_in   <= 1'b1;
        powerdown_set_in <= 1'b1;
        @(posedge clk_in);
        timeout_set_in   <= 1'b0;
        powerdown_set_in <= 1'b0;
        #1;
        check("to pd set", {6'h00, flags_out.timeout_flag, flags_out.powerdown_flag}, 8'h03);
        run_op(OP_CLEAR_WATCHDOG, 3'h0, 8'h00, 8'h00, 1'b0);
        check("wdt flags", {6'h00, flags_out.timeout_flag, flags_out.powerdown_flag}, 8'h00);
        check("wdt restart", {4'h0, watchdog_counter_out}, 8'h00);
        check("wdt carry kept", {7'h00, flags_out.carry_flag}, 8'h01);
        check("wdt zero kept", {7'h00, flags_out.zero_flag}, 8'h00);
        check("wdt expired low", {7'h00, watchdog_expired_out}, 8'h00);
        // The shortened counter runs out after 16 edges; all ones sets the timeout flag
        repeat (16) @(posedge clk_in);
        #1;
        check("wdt expired", {7'h00, watchdog_expired_out}, 8'h01);
        check("wdt wrapped", {4'h0, watchdog_counter_out}, 8'h00);
        $display("test watchdog clear done");
        tally_and_finish();
    end
endmodule
